//--- gvc_defs.svh
// Constants for the gamma and common-voltage serial register port
`ifndef GVC_DEFS_SVH
`define GVC_DEFS_SVH
`define GVC_DEV_ADDR 7'h74
`define GVC_HS_CODE 5'h01
`define GVC_GC_ADDR 8'h00
`define GVC_GC_RESET 8'h06
`define GVC_NV_SEL 2'h1
`define GVC_PTR_LAST 6'h17
`define GVC_PTR_GAMMA_LAST 6'h0F
`define GVC_PTR_COMMON_VOLTAGE_CHANNEL_A 6'h12
`define GVC_PTR_COMMON_VOLTAGE_CHANNEL_B 6'h13
`define GVC_PTR_ID 6'h3D
`define GVC_CODE_RESET 10'h200
`define GVC_ID_CODE 16'h1234
`define GVC_UPDATE_BIT 15
`define GVC_NCH 18
`endif

//--- gvc_pkg.sv
// Types for the gamma and common-voltage serial register port
package gvc_pkg;
    typedef enum logic [2:0] {
        GVC_IDLE, GVC_ADDR, GVC_PTR, GVC_WDATA, GVC_RDATA, GVC_GCDATA, GVC_IGNORE
    } gvc_state_type;
    typedef struct packed {
        logic scl;
        logic sda;
    } gvc_pins_type;
    typedef logic [9:0] gvc_code_type;
endpackage

//--- gvc_port.sv
// Two-wire slave port holding gamma and common-voltage codes
`timescale 1ns/1ns
`include "gvc_defs.svh"

// How it works
// R1: Start is data falling while clock high; it begins a transfer.
// R2: Address shifts in on rising clock; last bit is direction; ack in ninth clock.
// R3: Eight bits then ack; data change while clock high is start or stop.
// R4: Stop is data rising while clock high; it ends the transaction.
// R5: Clock line is input only, never driven.
// R6: Byte 00001xxx after start is high-speed master code, never acknowledged.
// R7: High-speed mode filters on after master code, kept until next stop.
// R8: General call 00h then 06h acks both and resets everything.
// R9: General-call address always acked; other general-call data not acked.
// R10: Power-up loads every channel with code 1000000000.
// R11: Sixteen gamma and two common-voltage channels, 10-bit codes each.
// R12: Word with bit 15 set moves its channel to output after 16th bit.
// R13: Bit 15 clear updates holding only; later set word updates all outputs. Here top bits 01 also update all outputs.
// R14: Pointer 111101 reads back a fixed 16-bit identity code.
// R15: First data byte top bits 01 target nonvolatile memory, else volatile.
// R16: Pointers 0..15 are gamma channels; 18 and 19 common-voltage channels.
// R17: Direction bit low means write, high means read.
// R18: Master sends pointer with top two bits clear, address in low six.
// R19: Pointers up to 010111 acked; unused addresses store nothing, read zero.
// R20: Data taken MSB first, bits 9..8 kept, each byte acked, update on second.
// R21: Stop or start before both data bytes leaves register unchanged.
// R22: Further data pairs auto-advance pointer until stop or start.
// R23: Twenty pairs from channel one; pairs 17,18 dropped, 19,20 common-voltage.
// R24: Master acks first read byte, ends with nack, stop or start.
// R25: Lines synchronised, edges from samples, glitch filter in high-speed mode.
module gvc_port (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire logic scl_clk_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b_out,
    output logic hs_mode_out,
    output logic nv_write_out,
    output logic [5:0] nv_addr_out,
    output gvc_pkg::gvc_code_type nv_data_out,
    output gvc_pkg::gvc_code_type [`GVC_NCH-1:0] level_out
);
    import gvc_pkg::*;

    // Link domain: sample data line on the link clock, three stages
    logic sda_l1, sda_l2, sda_l3;
    always_ff @(posedge scl_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sda_l1 <= 1'b1;
            sda_l2 <= 1'b1;
            sda_l3 <= 1'b1;
        end else begin
            sda_l1 <= sda_in;
            sda_l2 <= sda_l1;
            sda_l3 <= sda_l2;
        end
    end
    // Toggle on each sampled data-line change in the link domain; link clock stalls between frames so only a hint
    logic link_tog;
    always_ff @(posedge scl_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            link_tog <= 1'b0;
        end else if (sda_l3 != sda_l2) begin
            link_tog <= ~link_tog;
        end
    end

    // System domain: two-flop synchronisers on both pins [R25]
    gvc_pins_type pin_s1, pin_s2, pin_s3, pin_f;
    logic tog_s1, tog_s2;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1 <= 2'h3;
            pin_s2 <= 2'h3;
            pin_s3 <= 2'h3;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
        end else if (clk_en_in) begin
            pin_s1 <= '{scl: scl_clk_in, sda: sda_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
        end
    end

    // High-speed glitch filter: needs two agreeing samples in that mode [R25]
    logic hs_mode;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_f <= 2'h3;
        end else if (clk_en_in) begin
            if (!hs_mode || pin_s2 == pin_s3) begin
                pin_f <= pin_s2;
            end
        end
    end

    // Edge and condition detection from filtered samples
    gvc_pins_type pin_d;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_d <= 2'h3;
        end else if (clk_en_in) begin
            pin_d <= pin_f;
        end
    end
    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = pin_f.scl && !pin_d.scl;
    assign scl_fall = !pin_f.scl && pin_d.scl;
    assign start_det = pin_f.scl && pin_d.scl && pin_d.sda && !pin_f.sda; // [R1] [R3]
    assign stop_det = pin_f.scl && pin_d.scl && !pin_d.sda && pin_f.sda; // [R4] [R3]

    // Bit engine state
    gvc_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] msb_byte;
    logic byte_phase;
    logic [5:0] ptr;
    logic ack_phase;
    logic ack_drive;
    logic ack_on;
    logic ack_high;
    logic rd_bit;
    logic rd_nack;
    logic gc_reset;
    gvc_code_type [`GVC_NCH-1:0] hold;
    logic [15:0] rd_word;

    // Address decode for the pointer [R16] [R19]
    function automatic logic [4:0] chan_idx(input logic [5:0] p);
        if (p <= `GVC_PTR_GAMMA_LAST) begin
            chan_idx = p[4:0];
        end else if (p == `GVC_PTR_COMMON_VOLTAGE_CHANNEL_A) begin
            chan_idx = 5'h10;
        end else if (p == `GVC_PTR_COMMON_VOLTAGE_CHANNEL_B) begin
            chan_idx = 5'h11;
        end else begin
            chan_idx = 5'h1F;
        end
    endfunction

    // Read word mux; unused addresses read zero [R14] [R19]
    always_comb begin
        rd_word = 16'h0000;
        if (ptr == `GVC_PTR_ID) begin
            rd_word = `GVC_ID_CODE;
        end else if (chan_idx(ptr) != 5'h1F) begin
            rd_word = {6'h00, hold[chan_idx(ptr)]};
        end
    end

    logic [7:0] byte_in;
    assign byte_in = {shreg[6:0], pin_f.sda};

    // Completed write pair strobes
    logic pair_done, upd_now, nv_sel;
    logic [4:0] widx;
    assign pair_done = (state == GVC_WDATA) && scl_rise && bit_cnt == 4'h7 && byte_phase;
    assign nv_sel = msb_byte[7:6] == `GVC_NV_SEL; // [R15]
    assign upd_now = pair_done && msb_byte[`GVC_UPDATE_BIT-8]; // [R12] [R13]
    assign widx = chan_idx(ptr);

    // Serial protocol engine; start or stop aborts any half word [R21]
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= GVC_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            msb_byte <= 8'h00;
            byte_phase <= 1'b0;
            ptr <= 6'h00;
            ack_phase <= 1'b0;
            ack_drive <= 1'b0;
            ack_on <= 1'b0;
            ack_high <= 1'b0;
            rd_bit <= 1'b1;
            rd_nack <= 1'b0;
            gc_reset <= 1'b0;
            hs_mode <= 1'b0;
        end else if (clk_en_in) begin
            gc_reset <= 1'b0;
            if (stop_det) begin
                state <= GVC_IDLE;
                hs_mode <= 1'b0; // [R7]
                ack_phase <= 1'b0;
                ack_drive <= 1'b0;
                ack_on <= 1'b0;
                ack_high <= 1'b0;
                rd_bit <= 1'b1;
            end else if (start_det) begin
                state <= GVC_ADDR; // [R1]
                bit_cnt <= 4'h0;
                ack_phase <= 1'b0;
                ack_drive <= 1'b0;
                ack_on <= 1'b0;
                ack_high <= 1'b0;
                rd_bit <= 1'b1;
            end else if (scl_rise && !ack_phase) begin
                // Sample one bit per rising clock [R2] [R3]
                shreg <= byte_in;
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == 4'h7) begin
                    ack_phase <= 1'b1;
                    bit_cnt <= 4'h0;
                    // No ack owed unless a branch below grants one
                    ack_drive <= 1'b0;
                    case (state)
                        GVC_ADDR: begin
                            if (byte_in[7:3] == `GVC_HS_CODE) begin
                                hs_mode <= 1'b1; // [R6] [R7]
                                state <= GVC_IGNORE;
                            end else if (byte_in == `GVC_GC_ADDR) begin
                                ack_drive <= 1'b1; // [R9]
                                state <= GVC_GCDATA;
                            end else if (byte_in[7:1] == `GVC_DEV_ADDR) begin
                                ack_drive <= 1'b1; // [R2]
                                state <= byte_in[0] ? GVC_RDATA : GVC_PTR; // [R17]
                                byte_phase <= 1'b0;
                                rd_nack <= 1'b0;
                            end else begin
                                state <= GVC_IGNORE;
                            end
                        end
                        GVC_PTR: begin
                            ptr <= byte_in[5:0]; // [R18]
                            ack_drive <= byte_in[7:6] == 2'h0 && (byte_in[5:0] <= `GVC_PTR_LAST ||
                                byte_in[5:0] == `GVC_PTR_ID); // [R14] [R19]
                            state <= GVC_WDATA;
                            byte_phase <= 1'b0;
                        end
                        GVC_WDATA: begin
                            ack_drive <= 1'b1; // [R20]
                            byte_phase <= ~byte_phase;
                            if (!byte_phase) begin
                                msb_byte <= byte_in;
                            end else begin
                                ptr <= ptr + 6'h01; // [R22] [R23]
                            end
                        end
                        GVC_GCDATA: begin
                            ack_drive <= byte_in == `GVC_GC_RESET; // [R8] [R9]
                            gc_reset <= byte_in == `GVC_GC_RESET;
                            state <= GVC_IGNORE;
                        end
                        GVC_RDATA: begin
                            rd_nack <= pin_f.sda; // [R24]
                        end
                        default: begin
                            state <= GVC_IGNORE;
                        end
                    endcase
                end
            end else if (scl_rise && ack_phase) begin
                // Ninth clock high; on a read data byte the master's ack is taken
                ack_high <= 1'b1;
                if (state == GVC_RDATA && !ack_drive) begin
                    rd_nack <= pin_f.sda; // [R24]
                    byte_phase <= ~byte_phase;
                    if (byte_phase) begin
                        ptr <= ptr + 6'h01;
                    end
                end
            end else if (scl_fall) begin
                // Ack is held from the fall after bit eight to the fall after bit nine
                if (ack_phase && !ack_high) begin
                    ack_on <= ack_drive; // [R2]
                    rd_bit <= 1'b1;
                end else if (ack_phase) begin
                    ack_on <= 1'b0;
                    ack_drive <= 1'b0;
                    ack_high <= 1'b0;
                    ack_phase <= 1'b0;
                    rd_bit <= 1'b1;
                    if (state == GVC_RDATA) begin
                        if (rd_nack) begin
                            state <= GVC_IGNORE; // [R24]
                        end else begin
                            rd_bit <= byte_phase ? rd_word[7] : rd_word[15];
                        end
                    end
                end else if (state == GVC_RDATA && !rd_nack) begin
                    rd_bit <= byte_phase ? rd_word[3'h7 - bit_cnt[2:0]] :
                        rd_word[4'hF - {1'b0, bit_cnt[2:0]}];
                    if (bit_cnt == 4'h0) begin
                        rd_bit <= 1'b1;
                    end
                end else begin
                    rd_bit <= 1'b1;
                end
            end
        end
    end

    // Pin output: open drain, only data line driven; clock never driven [R5]
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sda_out <= 1'b0;
            sda_oe_b_out <= 1'b1;
        end else if (clk_en_in) begin
            sda_out <= 1'b0;
            sda_oe_b_out <= !(ack_on || !rd_bit); // [R2]
        end
    end

    // Holding and output registers per channel [R10] [R11] [R12] [R13] [R20]
    genvar gi;
    generate
        for (gi = 0; gi < `GVC_NCH; gi++) begin : g_chan
            always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    hold[gi] <= `GVC_CODE_RESET;
                    level_out[gi] <= `GVC_CODE_RESET;
                end else if (clk_en_in) begin
                    if (gc_reset) begin
                        hold[gi] <= `GVC_CODE_RESET; // [R8]
                        level_out[gi] <= `GVC_CODE_RESET;
                    end else begin
                        if (pair_done && widx == 5'(gi)) begin
                            hold[gi] <= {msb_byte[1:0], byte_in}; // [R20]
                        end
                        if (upd_now || (pair_done && nv_sel)) begin
                            level_out[gi] <= (pair_done && widx == 5'(gi)) ?
                                {msb_byte[1:0], byte_in} : hold[gi];
                        end
                    end
                end
            end
        end
    endgenerate

    // Status and nonvolatile request outputs
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hs_mode_out <= 1'b0;
            nv_write_out <= 1'b0;
            nv_addr_out <= 6'h00;
            nv_data_out <= 10'h000;
        end else if (clk_en_in) begin
            hs_mode_out <= hs_mode;
            nv_write_out <= pair_done && nv_sel && widx != 5'h1F; // [R15]
            if (pair_done) begin
                nv_addr_out <= ptr;
                nv_data_out <= {msb_byte[1:0], byte_in};
            end
        end
    end

    // Checks
    sequence start_s;
        pin_f.scl && pin_d.scl && pin_d.sda && !pin_f.sda;
    endsequence
    hs_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        clk_en_in && stop_det |=> !hs_mode) else $error("hs mode kept past stop"); // [R7]
    start_addr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (start_s and clk_en_in) |=> state == GVC_ADDR) else $error("start not seen"); // [R1]
    hs_enter_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // [R6]
        clk_en_in && state == GVC_ADDR && scl_rise && !ack_phase && bit_cnt == 4'h7 &&
        byte_in[7:3] == `GVC_HS_CODE |=> hs_mode) else $error("master code missed");
    ack_slot_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // [R2]
        clk_en_in && ack_on |=> sda_oe_b_out == 1'b0) else $error("ack not driven");
    gc_level_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        clk_en_in && gc_reset |=> level_out[0] == `GVC_CODE_RESET)
        else $error("general call reset missed"); // [R8]
    upd_level_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        clk_en_in && upd_now && widx == 5'h00 |=> level_out[0] == hold[0])
        else $error("output not updated"); // [R12]
    nv_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        nv_write_out |=> !nv_write_out) else $error("nv strobe too long"); // [R15]
endmodule // gvc_port

//--- gvc_master_model.sv
// Behavioural two-wire bus master facing the serial register port
`timescale 1ns/1ns
module gvc_master_model #(
    parameter int HALF = 40
) (
    input wire logic dut_sda_in,
    input wire logic dut_oe_b_in,
    output logic scl_out,
    output logic sda_line_out
);
    logic drv_low;
    // Open-drain data wire with pull-up; a released line reads high
    assign sda_line_out = !(drv_low || (!dut_oe_b_in && !dut_sda_in));
    initial begin
        scl_out = 1'b1;
        drv_low = 1'b0;
    end
    // Data moves only in the low phase; the low phase is two halves long
    // because the slave's ack comes through a synchroniser and lands late
    task automatic bit_out(input logic b);
        #HALF drv_low = !b;
        #HALF scl_out = 1'b1;
        #HALF scl_out = 1'b0;
    endtask
    // Release the line and sample it on the rising clock
    task automatic bit_in(output logic b);
        #HALF drv_low = 1'b0;
        #HALF scl_out = 1'b1;
        b = sda_line_out;
        #HALF scl_out = 1'b0;
    endtask
    // Start or repeated start: data falls while clock is high
    task automatic start_c();
        #HALF drv_low = 1'b0;
        #HALF scl_out = 1'b1;
        #HALF drv_low = 1'b1;
        #HALF scl_out = 1'b0;
    endtask
    // Stop: data rises while clock is high, then bus free time; clock idles high
    task automatic stop_c();
        #HALF drv_low = 1'b1;
        #HALF scl_out = 1'b1;
        #HALF drv_low = 1'b0;
        #(4 * HALF);
    endtask
    // Eight bits MSB first, then the slave's ack bit; also carries the master code
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i]);
        end
        bit_in(a);
        ack = !a;
    endtask
    // Read a byte; ack the first of a read, withhold it on the last
    task automatic get_byte(output logic [7:0] b, input logic ack_it);
        for (int i = 7; i >= 0; i--) begin
            bit_in(b[i]);
        end
        bit_out(!ack_it);
    endtask
endmodule // gvc_master_model

//--- testbench.sv
// Self-checking testbench for the serial gamma register port
`timescale 1ns/1ns
`include "gvc_defs.svh"
module testbench;
    import gvc_pkg::*;
    localparam logic [7:0] ADDR_W = {`GVC_DEV_ADDR, 1'b0};
    localparam logic [7:0] ADDR_R = {`GVC_DEV_ADDR, 1'b1};
    logic sys_clk, rst_b, scl, sda, sda_drv, oe_b, hs_mode, nv_write;
    logic [5:0] nv_addr;
    gvc_code_type nv_data;
    gvc_code_type [`GVC_NCH-1:0] level;
    logic [15:0] nv_seen;
    logic [15:0] rd;
    int error_cnt = 0;
    int check_count = 0;
    int nv_count = 0;
    gvc_port u_dut (
        .sys_clk_in(sys_clk),
        .rst_b_in(rst_b),
        .clk_en_in(1'b1),
        .scl_clk_in(scl),
        .sda_in(sda),
        .sda_out(sda_drv),
        .sda_oe_b_out(oe_b),
        .hs_mode_out(hs_mode),
        .nv_write_out(nv_write),
        .nv_addr_out(nv_addr),
        .nv_data_out(nv_data),
        .level_out(level)
    );
    gvc_master_model u_master (
        .dut_sda_in(sda_drv),
        .dut_oe_b_in(oe_b),
        .scl_out(scl),
        .sda_line_out(sda)
    );
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end
    // Nonvolatile strobe stands one cycle, so latch it here
    always @(posedge sys_clk) begin
        if (nv_write === 1'b1) begin
            nv_count++;
            nv_seen = {nv_addr, nv_data};
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic a;
        u_master.put_byte(b, a);
        check("ack", {15'h0000, a}, {15'h0000, exp_ack});
    endtask
    task automatic lvl(input int idx, input gvc_code_type exp);
        check("level", {6'h00, level[idx]}, {6'h00, exp});
    endtask
    // Address and pointer of a write, left open for data
    task automatic open_wr(input logic [5:0] ptr);
        u_master.start_c();
        send(ADDR_W, 1'b1);
        send({2'b00, ptr}, 1'b1);
    endtask
    task automatic pair(input logic [15:0] w);
        send(w[15:8], 1'b1);
        send(w[7:0], 1'b1);
    endtask
    task automatic wr_one(input logic [5:0] ptr, input logic [15:0] w);
        open_wr(ptr);
        pair(w);
        u_master.stop_c();
    endtask
    task automatic rd_reg(input logic [5:0] ptr, output logic [15:0] w);
        open_wr(ptr);
        u_master.start_c();
        send(ADDR_R, 1'b1);
        u_master.get_byte(w[15:8], 1'b1);
        u_master.get_byte(w[7:0], 1'b0);
        u_master.stop_c();
    endtask
    task automatic t_reset();
        for (int i = 0; i < `GVC_NCH; i++) begin
            lvl(i, 10'h200);
        end
        check("oe_b", {15'h0000, oe_b}, 16'h0001);
    endtask
    // Junk in bits 13..10 must be dropped; bit 15 clear only fills holding
    task automatic t_double_buffer();
        wr_one(6'h03, 16'h3D55);
        lvl(3, 10'h200);
        wr_one(6'h12, 16'h82AA);
        lvl(3, 10'h155);
        lvl(16, 10'h2AA);
        rd_reg(6'h03, rd);
        check("read", {6'h00, rd[9:0]}, 16'h0155);
    endtask
    // Six pairs from channel 14: two gaps dropped, last two land on common voltage
    task automatic t_auto();
        logic [15:0] w [6] = '{16'h0111, 16'h0122, 16'h0333, 16'h0344, 16'h0255, 16'h8266};
        open_wr(6'h0E);
        for (int i = 0; i < 6; i++) begin
            pair(w[i]);
        end
        u_master.stop_c();
        lvl(14, 10'h111);
        lvl(15, 10'h122);
        lvl(16, 10'h255);
        lvl(17, 10'h266);
    endtask
    // Lone MSB cut by a repeated start must not reach the register
    task automatic t_abort();
        open_wr(6'h05);
        send(8'h81, 1'b1);
        open_wr(6'h00);
        pair(16'h8001);
        u_master.stop_c();
        lvl(5, 10'h200);
        lvl(0, 10'h001);
    endtask
    task automatic t_refuse();
        u_master.start_c();
        send({`GVC_DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
        u_master.stop_c();
        u_master.start_c();
        send(ADDR_W, 1'b1);
        send(8'h18, 1'b0);
        u_master.stop_c();
        wr_one(6'h17, 16'h8123);
        lvl(17, 10'h266);
        rd_reg(6'h10, rd);
        check("read gap", rd, 16'h0000);
        rd_reg(`GVC_PTR_ID, rd);
        check("identity", rd, `GVC_ID_CODE);
    endtask
    task automatic t_nv();
        check("nv count", nv_count[15:0], 16'h0000);
        wr_one(6'h07, 16'h41AB);
        check("nv count", nv_count[15:0], 16'h0001);
        check("nv word", nv_seen, {6'h07, 10'h1AB});
    endtask
    task automatic t_hs();
        u_master.start_c();
        send(8'h0B, 1'b0);
        check("hs", {15'h0000, hs_mode}, 16'h0001);
        open_wr(6'h08);
        pair(16'h8077);
        open_wr(6'h09);
        check("hs", {15'h0000, hs_mode}, 16'h0001);
        u_master.stop_c();
        check("hs", {15'h0000, hs_mode}, 16'h0000);
        lvl(8, 10'h077);
    endtask
    task automatic t_gc();
        u_master.start_c();
        send(`GVC_GC_ADDR, 1'b1);
        send(8'h05, 1'b0);
        u_master.stop_c();
        lvl(0, 10'h001);
        u_master.start_c();
        send(`GVC_GC_ADDR, 1'b1);
        send(`GVC_GC_RESET, 1'b1);
        u_master.stop_c();
        for (int i = 0; i < `GVC_NCH; i++) begin
            lvl(i, 10'h200);
        end
    endtask
    // Guard against a hang anywhere in the sequence
    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        rst_b = 1'b0;
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge sys_clk);
        #3;
        t_reset();
        t_double_buffer();
        t_auto();
        t_abort();
        t_refuse();
        t_nv();
        t_hs();
        t_gc();
        report_and_stop();
    end
endmodule // testbench
